/* File: rtl/tone_pkg.sv */
package tone_pkg;

  // time base: one millisecond of the system clock
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned CYCLES_PER_MS = CLK_HZ / MS_PER_S;
  localparam int MS_CNT_BITS = 18;

  // command fields
  localparam int PIN_COUNT = 16;
  localparam int PIN_BITS = 4;
  localparam int FREQ_BITS = 15;
  localparam logic [15:0] DUR_MIN = 16'h0001;

  // phase step = freq * 2^32 / CLK_HZ, approximated as freq * STEP_MULT >> STEP_SHIFT
  localparam logic [17:0] STEP_MULT = 18'h1_12E1;
  localparam int STEP_SHIFT = 12;
  localparam int PHASE_BITS = 32;

  // modulator: 512-cycle frame, mid-scale duty is silence
  localparam int PWM_BITS = 9;
  localparam logic [9:0] DUTY_MID = 10'h100;

  // controller states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_PLAY = 2'b10
  } play_state_t;

endpackage

/* File: rtl/tone_if.sv */
`timescale 1ns/10ps
`default_nettype none

interface tone_if;
  logic run;
  logic two;
  logic [31:0] step_a;
  logic [31:0] step_b;
  logic pwm;

  modport ctrl (output run, output two, output step_a, output step_b, input pwm);
  modport synth (input run, input two, input step_a, input step_b, output pwm);
endinterface

`default_nettype wire

/* File: rtl/tone_synth.sv */
`timescale 1ns/10ps
`default_nettype none

module tone_synth
  import tone_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // controller side
  tone_if.synth tb
);

  typedef struct packed {
    logic [31:0] phase_a;
    logic [31:0] phase_b;
    logic [8:0] pwm_cnt;
    logic [9:0] duty;
    logic pwm;
  } synth_state_t;

  synth_state_t s;
  synth_state_t next_s;
  logic signed [8:0] sine_a;
  logic signed [8:0] sine_b;
  logic signed [9:0] mixed;

  ////////////////////////////////////////////////////////////////////////////
  // parabolic half-wave sine; phase zero gives zero, so a stopped tone is mute
  function automatic logic signed [8:0] half_sine(input logic [31:0] ph);
    logic [7:0] x;
    logic [15:0] p;
    logic [8:0] mag;
    x = ph[30:23];
    p = x * (8'hFF - x);
    mag = {1'b0, p[13:6]};
    return ph[31] ? -$signed(mag) : $signed(mag);
  endfunction

  // mixing: two tones halve their sum so the duty never leaves range
  always_comb begin
    sine_a = half_sine(s.phase_a);
    sine_b = half_sine(s.phase_b);
    if (tb.two) begin
      mixed = (10'(sine_a) + 10'(sine_b)) >>> 1;
    end else begin
      mixed = 10'(sine_a);
    end
  end

  // phase accumulators and pwm frame; duty updates once per frame
  always_comb begin
    next_s = s;
    next_s.pwm_cnt = s.pwm_cnt + 9'h001;
    if (s.pwm_cnt == '1) begin
      next_s.duty = DUTY_MID + 10'(mixed);
    end
    next_s.pwm = ({1'b0, s.pwm_cnt} < s.duty);
    if (tb.run) begin
      next_s.phase_a = s.phase_a + tb.step_a;
      next_s.phase_b = s.phase_b + tb.step_b;
    end else begin
      // restart at phase zero so each command begins cleanly
      next_s.phase_a = '0;
      next_s.phase_b = '0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s <= '{phase_a: 32'h0000_0000, phase_b: 32'h0000_0000, pwm_cnt: 9'h000,
             duty: 10'h100, pwm: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign tb.pwm = s.pwm;

  ////////////////////////////////////////////////////////////////////////////
  a_zero_silent: assert property (@(posedge clk_sys) disable iff (rst)
    (tb.run && tb.step_a == 0 && tb.step_b == 0)[*2] |-> mixed == 0)
    else $error("zero frequencies did not give silence");

  a_duty_range: assert property (@(posedge clk_sys) disable iff (rst)
    s.duty >= 10'h002 && s.duty <= 10'h1FE)
    else $error("duty left modulator range");

  a_mix_sum: assert property (@(posedge clk_sys) disable iff (rst)
    (tb.two && s.pwm_cnt == '1) |=> s.duty == DUTY_MID + 10'(($past(10'(sine_a))
    + $past(10'(sine_b))) >>> 1))
    else $error("two-tone mix not loaded into duty");

  a_pwm_follow: assert property (@(posedge clk_sys) disable iff (rst)
    (s.pwm_cnt == 9'h000) |-> ##1 (s.pwm == (s.duty != 0))[*1])
    else $error("pwm frame did not start high for a nonzero duty");

endmodule

`default_nettype wire

/* File: rtl/tone_gen.sv */
`timescale 1ns/10ps
`default_nettype none

module tone_gen
  import tone_pkg::*;
#(
  parameter int unsigned MS_CYCLES = CYCLES_PER_MS
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // command
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [3:0] cmd_pin,
  input wire logic [15:0] cmd_duration,
  input wire logic [15:0] first_tone_frequency,
  input wire logic [15:0] second_tone_frequency,
  input wire logic cmd_two_tones,
  // status
  output logic busy,
  output logic done,
  // i/o pins
  output logic [15:0] pin_out,
  output logic [15:0] pin_oe_n
);

  typedef struct packed {
    play_state_t st;
    logic [MS_CNT_BITS-1:0] ms_cnt;
    logic [15:0] dur_left;
    logic [PIN_BITS-1:0] pin_sel;
    logic [PIN_COUNT-1:0] dir;
    logic [PIN_COUNT-1:0] pins;
    logic [31:0] step_a;
    logic [31:0] step_b;
    logic two;
    logic done;
  } gen_state_t;

  gen_state_t s;
  gen_state_t next_s;
  logic take;

  tone_if tbus ();

  ////////////////////////////////////////////////////////////////////////////
  // hertz to phase step; the top bit is ignored, so 32768 means silence
  function automatic logic [31:0] tone_step(input logic [15:0] freq);
    logic [14:0] f;
    logic [32:0] prod;
    f = freq[FREQ_BITS-1:0];
    prod = f * STEP_MULT;
    // the product stays below 2^32, so the shifted value always fits the step
    return 32'(prod >> STEP_SHIFT);
  endfunction

  assign take = cmd_valid && (s.st == ST_IDLE);

  // command acceptance, millisecond count-down and pin steering
  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    case (s.st)
      ST_IDLE: begin
        if (cmd_valid) begin
          next_s.st = ST_PLAY;
          next_s.pin_sel = cmd_pin;
          next_s.dir[cmd_pin] = 1'b1;
          next_s.ms_cnt = '0;
          // a zero duration is outside the legal range; play the shortest
          next_s.dur_left = (cmd_duration == 16'h0000) ? DUR_MIN : cmd_duration;
          next_s.step_a = tone_step(first_tone_frequency);
          next_s.step_b = cmd_two_tones ? tone_step(second_tone_frequency) : '0;
          next_s.two = cmd_two_tones;
        end
      end
      ST_PLAY: begin
        next_s.pins = '0;
        next_s.pins[s.pin_sel] = tbus.pwm;
        if (s.ms_cnt == MS_CNT_BITS'(MS_CYCLES - 1)) begin
          next_s.ms_cnt = '0;
          if (s.dur_left == DUR_MIN) begin
            // pin stays an output, parked low
            next_s.st = ST_IDLE;
            next_s.pins = '0;
            next_s.done = 1'b1;
          end else begin
            next_s.dur_left = s.dur_left - 16'h0001;
          end
        end else begin
          next_s.ms_cnt = s.ms_cnt + MS_CNT_BITS'(1);
        end
      end
      default: begin
        next_s.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s <= '{st: ST_IDLE, ms_cnt: '0, dur_left: 16'h0000, pin_sel: 4'h0, dir: 16'h0000,
             pins: 16'h0000, step_a: 32'h0000_0000, step_b: 32'h0000_0000,
             two: 1'b0, done: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  // synthesizer runs only while a command is being played
  assign tbus.run = (s.st == ST_PLAY);
  assign tbus.two = s.two;
  assign tbus.step_a = s.step_a;
  assign tbus.step_b = s.step_b;

  tone_synth u_synth (
    .clk_sys(clk_sys),
    .rst(rst),
    .tb(tbus.synth)
  );

  assign cmd_ready = (s.st == ST_IDLE);
  assign busy = (s.st == ST_PLAY);
  assign done = s.done;
  assign pin_out = s.pins;
  assign pin_oe_n = ~s.dir;

  ////////////////////////////////////////////////////////////////////////////
  a_dir_sticky: assert property (@(posedge clk_sys) disable iff (rst)
    ((~$past(pin_oe_n)) & pin_oe_n) == 16'h0000)
    else $error("a pin left output mode");

  a_start_drive: assert property (@(posedge clk_sys) disable iff (rst)
    take |=> (pin_oe_n[$past(cmd_pin)] == 1'b0 && busy))
    else $error("selected pin not switched to output");

  a_quiet_pins: assert property (@(posedge clk_sys) disable iff (rst)
    (pin_out & ~(16'h0001 << s.pin_sel)) == 16'h0000)
    else $error("unselected pin driven high");

  a_dur_clamp: assert property (@(posedge clk_sys) disable iff (rst)
    (take && cmd_duration == 16'h0000) |=> s.dur_left == DUR_MIN)
    else $error("zero duration not clamped to one");

  a_ms_step: assert property (@(posedge clk_sys) disable iff (rst)
    (busy && s.ms_cnt != MS_CNT_BITS'(MS_CYCLES - 1)) |=> $stable(s.dur_left))
    else $error("duration changed inside a millisecond");

  a_msb_drop: assert property (@(posedge clk_sys) disable iff (rst)
    (take && first_tone_frequency == 16'h8000) |=> s.step_a == 32'h0000_0000)
    else $error("bit fifteen of frequency was used");

  a_single_full: assert property (@(posedge clk_sys) disable iff (rst)
    (take && !cmd_two_tones) |=> (!s.two && s.step_b == 32'h0000_0000))
    else $error("single tone treated as a mix");

endmodule

`default_nettype wire

/* File: verification/tone_filter.sv */
`timescale 1ns/10ps
`default_nettype none

// lossless integrator standing in for the rc filter, so a short play still shows its mean duty
module tone_filter (
  // clock and clear
  input wire logic clk_sys,
  input wire logic clear,
  // pin being filtered
  input wire logic pin,
  output int high_cnt
);
  // charge rises only while the pin is high; an idle pin is parked low
  always_ff @(posedge clk_sys) begin
    if (clear) begin
      high_cnt <= 0;
    end else begin
      high_cnt <= high_cnt + int'(pin);
    end
  end
endmodule

`default_nettype wire

/* File: verification/dual_tone_pwm_generator_test.sv */
`timescale 1ns/10ps
`default_nettype none

module dual_tone_pwm_generator_test;
  import tone_pkg::*;
  localparam int MS = 1024; // two pwm frames per millisecond keeps runs short
  localparam int LIM = 20000;
  typedef struct {logic [3:0] p; logic [15:0] d, f1, f2; logic two; int kind;} row_t;
  logic clk_sys, rst, cmd_valid, cmd_two_tones, clear, cmd_ready, busy, done;
  logic [3:0] cmd_pin;
  logic [15:0] cmd_duration, first_tone_frequency, second_tone_frequency, pin_out, pin_oe_n;
  int failures, samples_checked, hi, n;
  int dev[7];
  row_t rows[7] = '{'{4'h2, 16'h0002, 16'h0000, 16'h0000, 1'b0, 0},
    '{4'hF, 16'h0002, 16'h8000, 16'h8000, 1'b1, 0}, '{4'h0, 16'h0002, 16'hFFFF, 16'h0000, 1'b0, 1},
    '{4'h7, 16'h0002, 16'h7FFF, 16'h0000, 1'b0, 1}, '{4'h9, 16'h0002, 16'h7FFF, 16'h0000, 1'b1, 1},
    '{4'h4, 16'h0002, 16'h7FFF, 16'h7FFF, 1'b1, 1}, '{4'h1, 16'h0001, 16'h0000, 16'h0000, 1'b0, 0}};

  tone_gen #(.MS_CYCLES(MS)) dut (.clk_sys(clk_sys), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_pin(cmd_pin), .cmd_duration(cmd_duration),
    .first_tone_frequency(first_tone_frequency), .second_tone_frequency(second_tone_frequency),
    .cmd_two_tones(cmd_two_tones), .busy(busy), .done(done), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n));
  tone_filter filt (.clk_sys(clk_sys), .clear(clear), .pin(pin_out[cmd_pin]), .high_cnt(hi));

  ////////////////////////////////////////////////////////////////////////////////
  // 250 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic int mag(input int v);
    return (v < 0) ? -v : v;
  endfunction

  task automatic print_verdict();
    $display("checked %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // counts edges from the take to done, checking status and idle pins every cycle
  task automatic wait_done(input logic [3:0] pp);
    n = 0;
    do begin
      @(posedge clk_sys);
      #1;
      n++;
      chk(busy ^ done, 1'b1);
      chk(cmd_ready, done);
      chk(pin_out & ~(16'h0001 << pp), 16'h0000);
    end while (done !== 1'b1 && n < LIM);
    if (n >= LIM) begin
      failures++;
      print_verdict();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {cmd_valid, cmd_two_tones, cmd_pin, cmd_duration} = '0;
    {first_tone_frequency, second_tone_frequency} = '0;
    {failures, samples_checked} = '0;
    rst = 1'b1;
    clear = 1'b1;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    // table: filtered charge tells silence from tone; deviation is twice the mean offset
    for (int i = 0; i < 7; i++) begin
      // idle gap latches mid duty and puts every take at the same frame offset
      repeat (1023) @(posedge clk_sys);
      {cmd_pin, cmd_duration, cmd_two_tones} <= {rows[i].p, rows[i].d, rows[i].two};
      {first_tone_frequency, second_tone_frequency} <= {rows[i].f1, rows[i].f2};
      cmd_valid <= 1'b1;
      clear <= 1'b1;
      @(posedge clk_sys);
      cmd_valid <= 1'b0;
      clear <= 1'b0;
      wait_done(rows[i].p);
      chk(n, 32'(rows[i].d) * MS);
      chk(pin_oe_n[rows[i].p], 1'b0);
      dev[i] = 2 * hi - int'(rows[i].d) * MS;
      chk(32'(mag(dev[i]) > 64), 32'(rows[i].kind));
    end
    chk(32'(dev[2] == dev[3]), 1);
    chk(32'(mag(dev[4]) < mag(dev[3]) && mag(dev[4]) > 32), 1);
    chk(32'(mag(dev[5] - dev[3]) <= mag(dev[3]) / 4), 1);
    // a command held through a play is refused, then taken on the edge after done
    @(posedge clk_sys);
    {cmd_pin, cmd_duration, cmd_valid} <= {4'h3, 16'h0001, 1'b1};
    @(posedge clk_sys);
    cmd_pin <= 4'h5;
    wait_done(4'h3);
    chk(n, MS);
    chk(pin_oe_n[5], 1'b1);
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    #1;
    chk(busy, 1'b1);
    chk(pin_oe_n[5], 1'b0);
    // reset in mid-play frees every pin and returns to idle
    repeat (3) @(posedge clk_sys);
    rst <= 1'b1;
    @(posedge clk_sys);
    #1;
    chk({busy, done, cmd_ready}, 3'b001);
    chk({pin_out, pin_oe_n}, 32'h0000_FFFF);
    rst <= 1'b0;
    // still idle two edges after release
    repeat (2) @(posedge clk_sys);
    #1;
    chk({busy, done, cmd_ready}, 3'b001);
    chk({pin_out, pin_oe_n}, 32'h0000_FFFF);
    print_verdict();
  end
endmodule

`default_nettype wire
